//--- design/node_led_regs.svh
// Register offsets, field positions and timing counts of the status indicator block
`ifndef NODE_LED_REGS_SVH
`define NODE_LED_REGS_SVH

// Register word addresses (byte address = 4 * index)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_IRQ_STAT 4'h2
`define REG_IRQ_MASK 4'h3
`define REG_LEDS 4'h4
`define REG_SELECTOR 4'h5

// Control register fields
`define CTRL_NMT_LO 0
`define CTRL_NMT_HI 1
`define CTRL_INIT_OK 2
`define CTRL_INIT_FAIL 3
`define CTRL_BAUD_SEL 4
`define CTRL_ID_SEL 5
`define CTRL_RESYNC 6
`define CTRL_TIME_VALID 7
`define CTRL_WIDTH 8
`define CTRL_RESET 8'h00

// Interrupt status fields
`define IRQ_BUS_LOST 0
`define IRQ_BATT_FAIL 1
`define IRQ_TIME_RX 2
`define IRQ_WIDTH 3
`define IRQ_RESET 3'h0

// Selector field layout: low six bits node id, top two bits bit rate
`define SEL_ID_HI 5
`define SEL_RATE_LO 6
`define SEL_RATE_HI 7

// Blink timing
`define CLK_HZ 200000000
`define HALF_1HZ_MS 500
`define HALF_10HZ_MS 50
`define CYC_HALF_1HZ ((`CLK_HZ / 1000) * `HALF_1HZ_MS)
`define CYC_HALF_10HZ ((`CLK_HZ / 1000) * `HALF_10HZ_MS)

`endif

//--- design/node_led_pkg.sv
// Types shared by the status indicator block
package node_led_pkg;

  typedef enum logic [1:0] {
    NMT_NONE = 2'h0,
    NMT_PREOP = 2'h1,
    NMT_OPER = 2'h3,
    NMT_STOPPED = 2'h2
  } nmt_state_e;

  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_ID_SEL = 2'h1,
    MODE_BAUD_SEL = 2'h3,
    MODE_INIT_FAIL = 2'h2
  } panel_mode_e;

  typedef struct packed {
    logic supply_present_led;
    logic fault_led;
    logic ready_led;
    logic bus_active_led;
    logic cell_fault_led;
    logic clock_resync_led;
    logic time_received_led;
  } led_bank_s;

  typedef struct packed {
    logic bus_present;
    logic backplane_busy;
    logic cell_fault;
  } pin_in_s;

endpackage : node_led_pkg

//--- design/node_status_led_driver.sv
// Front panel status indicator driver with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
`include "node_led_regs.svh"

module node_status_led_driver
  import node_led_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Status pins from outside the clock domain
  input wire logic i_bus_present,
  input wire logic i_backplane_busy,
  input wire logic i_cell_fault,
  input wire logic [7:0] i_selector,
  // Indicators and results
  output var led_bank_s o_leds,
  output logic [5:0] o_node_id,
  output logic [1:0] o_bit_rate,
  output logic o_irq
);

  localparam int unsigned HALF_1HZ = `CYC_HALF_1HZ;
  localparam int unsigned HALF_10HZ = `CYC_HALF_10HZ;

  // Three-stage pin synchronisers; a change counts once stages two and three agree
  pin_in_s pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  logic [7:0] sel_s1_q, sel_s2_q, sel_s3_q, sel_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
      sel_s1_q <= 8'h00;
      sel_s2_q <= 8'h00;
      sel_s3_q <= 8'h00;
      sel_q <= 8'h00;
    end else begin
      pin_s1_q <= pin_in_s'{i_bus_present, i_backplane_busy, i_cell_fault};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_q <= pin_s3_q;
      end
      sel_s1_q <= i_selector;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      if (sel_s2_q == sel_s3_q) begin
        sel_q <= sel_s3_q;
      end
    end
  end

  // Node id and bit rate both come from the selector switch
  // selector decode
  assign o_node_id = sel_q[`SEL_ID_HI:0];
  assign o_bit_rate = sel_q[`SEL_RATE_HI:`SEL_RATE_LO];

  // Blink generators: phase toggles every half period
  logic [27:0] cnt_1hz_q, cnt_10hz_q;
  logic blink_1hz_q, blink_10hz_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_1hz_q <= 28'h0;
      blink_1hz_q <= 1'b0;
    end else if (cnt_1hz_q == 28'(HALF_1HZ - 1)) begin
      cnt_1hz_q <= 28'h0;
      blink_1hz_q <= ~blink_1hz_q;
    end else begin
      cnt_1hz_q <= cnt_1hz_q + 28'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_10hz_q <= 28'h0;
      blink_10hz_q <= 1'b0;
    end else if (cnt_10hz_q == 28'(HALF_10HZ - 1)) begin
      cnt_10hz_q <= 28'h0;
      blink_10hz_q <= ~blink_10hz_q;
    end else begin
      cnt_10hz_q <= cnt_10hz_q + 28'h1;
    end
  end

  // Control register written by firmware
  logic [`CTRL_WIDTH-1:0] ctrl_q;
  logic [`IRQ_WIDTH-1:0] irq_stat_q, irq_mask_q;
  logic wr_ctrl, wr_stat, wr_mask;

  assign wr_ctrl = i_avs_write && (i_avs_address == `REG_CTRL);
  assign wr_stat = i_avs_write && (i_avs_address == `REG_IRQ_STAT);
  assign wr_mask = i_avs_write && (i_avs_address == `REG_IRQ_MASK);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= i_avs_writedata[`CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_mask_q <= `IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= i_avs_writedata[`IRQ_WIDTH-1:0];
    end
  end

  nmt_state_e nmt;
  panel_mode_e mode;
  assign nmt = nmt_state_e'(ctrl_q[`CTRL_NMT_HI:`CTRL_NMT_LO]);

  // Init failure outranks the selection modes, bit-rate select outranks id select
  always_comb begin
    if (ctrl_q[`CTRL_INIT_FAIL]) begin
      mode = MODE_INIT_FAIL;
    end else if (ctrl_q[`CTRL_BAUD_SEL]) begin
      mode = MODE_BAUD_SEL;
    end else if (ctrl_q[`CTRL_ID_SEL]) begin
      mode = MODE_ID_SEL;
    end else begin
      mode = MODE_RUN;
    end
  end

  // Indicator pattern
  led_bank_s leds_d;

  always_comb begin
    leds_d = '0;
    leds_d.supply_present_led = 1'b1;
    leds_d.cell_fault_led = pin_q.cell_fault;
    leds_d.clock_resync_led = ctrl_q[`CTRL_RESYNC];
    leds_d.time_received_led = ctrl_q[`CTRL_TIME_VALID];
    unique case (mode)
      MODE_INIT_FAIL: begin
        leds_d.fault_led = 1'b1;
        leds_d.ready_led = 1'b1;
        leds_d.bus_active_led = 1'b1;
      end
      MODE_BAUD_SEL: begin
        leds_d.fault_led = blink_1hz_q;
        leds_d.ready_led = blink_1hz_q;
        leds_d.bus_active_led = blink_1hz_q;
      end
      MODE_ID_SEL: begin
        leds_d.ready_led = blink_1hz_q;
      end
      MODE_RUN: begin
        leds_d.fault_led = !pin_q.bus_present && blink_10hz_q;
        if (pin_q.backplane_busy) begin
          leds_d.ready_led = 1'b1;
        end else if (ctrl_q[`CTRL_INIT_OK]) begin
          leds_d.ready_led = blink_1hz_q;
        end
        unique case (nmt)
          NMT_OPER: leds_d.bus_active_led = 1'b1;
          NMT_PREOP: leds_d.bus_active_led = blink_1hz_q;
          NMT_STOPPED: leds_d.bus_active_led = blink_10hz_q;
          NMT_NONE: leds_d.bus_active_led = 1'b0;
        endcase
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_leds <= '0;
    end else begin
      o_leds <= leds_d;
    end
  end

  // Sticky events: bus lost, battery fault rising, time valid rising
  logic bus_prev_q, cell_prev_q, time_prev_q;
  logic [`IRQ_WIDTH-1:0] ev;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_prev_q <= 1'b0;
      cell_prev_q <= 1'b0;
      time_prev_q <= 1'b0;
    end else begin
      bus_prev_q <= pin_q.bus_present;
      cell_prev_q <= pin_q.cell_fault;
      time_prev_q <= ctrl_q[`CTRL_TIME_VALID];
    end
  end

  always_comb begin
    ev = '0;
    ev[`IRQ_BUS_LOST] = bus_prev_q && !pin_q.bus_present;
    ev[`IRQ_BATT_FAIL] = !cell_prev_q && pin_q.cell_fault;
    ev[`IRQ_TIME_RX] = !time_prev_q && ctrl_q[`CTRL_TIME_VALID];
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_q <= `IRQ_RESET;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? i_avs_writedata[`IRQ_WIDTH-1:0] : '0)) | ev;
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // Read word selected by the address
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0;
    unique case (i_avs_address)
      `REG_CTRL: rd_word[`CTRL_WIDTH-1:0] = ctrl_q;
      `REG_STATUS: rd_word[$bits(pin_in_s)-1:0] = pin_q;
      `REG_IRQ_STAT: rd_word[`IRQ_WIDTH-1:0] = irq_stat_q;
      `REG_IRQ_MASK: rd_word[`IRQ_WIDTH-1:0] = irq_mask_q;
      `REG_LEDS: rd_word[$bits(led_bank_s)-1:0] = o_leds;
      `REG_SELECTOR: rd_word[$bits(sel_q)-1:0] = sel_q;
      default: rd_word = 32'h0;
    endcase
  end

  // Read data comes from a flip-flop, so a read waits one cycle for its capture
  logic rd_done_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_done_q <= 1'b0;
      o_avs_readdata <= 32'h0;
    end else begin
      rd_done_q <= i_avs_read && !rd_done_q;
      if (i_avs_read && !rd_done_q) begin
        o_avs_readdata <= rd_word;
      end
    end
  end

  // Writes never wait
  assign o_avs_waitrequest = i_avs_read && !rd_done_q;

  // Assertions
  sequence s_fail_mode;
    mode == MODE_INIT_FAIL;
  endsequence

  a_fail_all_on: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    s_fail_mode |=> (o_leds.fault_led && o_leds.ready_led && o_leds.bus_active_led
      && o_leds.supply_present_led))
    else $error("init failure pattern wrong");

  a_bus_lost_blink: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode == MODE_RUN && !pin_q.bus_present) |=> (o_leds.fault_led == $past(blink_10hz_q)))
    else $error("fault lamp not following fast blink");

  a_ready_busy: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode == MODE_RUN && pin_q.backplane_busy) |=> o_leds.ready_led)
    else $error("ready lamp not steady during transfer");

  a_ready_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode == MODE_RUN && !pin_q.backplane_busy && ctrl_q[`CTRL_INIT_OK])
      |=> (o_leds.ready_led == $past(blink_1hz_q)))
    else $error("ready lamp not slow blinking");

  a_bus_oper: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode == MODE_RUN && nmt == NMT_OPER) |=> o_leds.bus_active_led)
    else $error("bus lamp not steady in operational");

  a_bus_none_dark: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode == MODE_RUN && nmt == NMT_NONE) |=> !o_leds.bus_active_led)
    else $error("bus lamp lit without network state");

  a_bus_preop: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode == MODE_RUN && nmt == NMT_PREOP) |=> (o_leds.bus_active_led == $past(blink_1hz_q)))
    else $error("bus lamp not slow blinking");

  a_bus_stopped: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode == MODE_RUN && nmt == NMT_STOPPED)
      |=> (o_leds.bus_active_led == $past(blink_10hz_q)))
    else $error("bus lamp not fast blinking");

  a_batt_lamp: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ##1 (o_leds.cell_fault_led == $past(pin_q.cell_fault)))
    else $error("battery lamp mismatch");

  a_baud_pattern: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode == MODE_BAUD_SEL) |=> (o_leds.fault_led == o_leds.ready_led
      && o_leds.ready_led == o_leds.bus_active_led))
    else $error("bit-rate select lamps not together");

  a_id_pattern: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode == MODE_ID_SEL) |=> (!o_leds.fault_led && !o_leds.bus_active_led))
    else $error("id select lamps not dark");

  a_resync_lamp: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ##1 (o_leds.clock_resync_led == $past(ctrl_q[`CTRL_RESYNC])))
    else $error("resync lamp mismatch");

  a_time_lamp: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ##1 (o_leds.time_received_led == $past(ctrl_q[`CTRL_TIME_VALID])))
    else $error("time lamp mismatch");

  sequence s_read_wait;
    i_avs_read && o_avs_waitrequest;
  endsequence

  a_read_answer: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    s_read_wait |=> !o_avs_waitrequest)
    else $error("read not answered after one wait state");

endmodule : node_status_led_driver
`default_nettype wire

//--- bench/node_status_src.sv
// Model of the status sources that feed the indicator block pins
`timescale 1ns/100ps
`default_nettype none
module node_status_src
  import node_led_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Commanded pin levels
  input wire pin_in_s i_pins_cmd,
  input wire logic [7:0] i_sel_cmd,
  // Pin levels as the block sees them
  output var pin_in_s o_pins,
  output logic [7:0] o_selector
);
  // Pins move just after an edge, like a real source sampled by a register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pins <= '0;
      o_selector <= 8'h00;
    end else begin
      o_pins <= i_pins_cmd;
      o_selector <= i_sel_cmd;
    end
  end
endmodule : node_status_src
`default_nettype wire

//--- bench/tb_node_status_led_driver.sv
// Self-checking bench of the status indicator block
`timescale 1ns/100ps
`default_nettype none
`include "node_led_regs.svh"
module tb_node_status_led_driver
  import node_led_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  pin_in_s pins_cmd = '0;
  pin_in_s pins;
  logic [7:0] sel_cmd = 8'h00;
  logic [7:0] selector;
  led_bank_s leds;
  logic [5:0] node_id;
  logic [1:0] bit_rate;
  logic irq;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] rd;

  // Row: ctrl, pins {bus, busy, cell}, selector, expected lamps
  localparam logic [25:0] ROWS [8] = '{
    {8'h07, 3'b100, 8'hc5, 7'h48}, {8'h05, 3'b110, 8'h3f, 7'h50},
    {8'h06, 3'b101, 8'h40, 7'h44}, {8'hc4, 3'b100, 8'h80, 7'h43},
    {8'h08, 3'b100, 8'h01, 7'h78}, {8'h13, 3'b110, 8'hff, 7'h40},
    {8'h23, 3'b110, 8'h00, 7'h40}, {8'h07, 3'b000, 8'h2a, 7'h48}};

  always #2.5 sys_clk = ~sys_clk;

  node_status_src node_status_src_inst (.i_sys_clk(sys_clk), .i_rstn(rstn),
    .i_pins_cmd(pins_cmd), .i_sel_cmd(sel_cmd), .o_pins(pins), .o_selector(selector));

  node_status_led_driver node_status_led_driver_inst (.i_sys_clk(sys_clk), .i_rstn(rstn),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .i_bus_present(pins.bus_present),
    .i_backplane_busy(pins.backplane_busy), .i_cell_fault(pins.cell_fault),
    .i_selector(selector), .o_leds(leds), .o_node_id(node_id), .o_bit_rate(bit_rate),
    .o_irq(irq));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : av_xfer

  task automatic set_pins(input logic [2:0] p);
    @(posedge sys_clk);
    pins_cmd <= p;
    repeat (10) @(posedge sys_clk);
  endtask : set_pins

  initial begin
    repeat (3) @(posedge sys_clk);
    chk({25'h0, leds}, 32'h0); // lamps dark in reset
    chk({31'h0, irq}, 32'h0);
    rstn <= 1'b1;
    av_xfer(1'b0, `REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    av_xfer(1'b0, `REG_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      av_xfer(1'b1, `REG_CTRL, {24'h0, ROWS[i][25:18]});
      sel_cmd <= ROWS[i][14:7];
      set_pins(ROWS[i][17:15]);
      chk({25'h0, leds}, {25'h0, ROWS[i][6:0]});
      av_xfer(1'b0, `REG_LEDS, 32'h0);
      chk(rd, {25'h0, ROWS[i][6:0]});
      chk({26'h0, node_id}, {26'h0, ROWS[i][12:7]});
      chk({30'h0, bit_rate}, {30'h0, ROWS[i][14:13]});
    end
    // Event flags, mask and clear
    av_xfer(1'b1, `REG_CTRL, 32'h04);
    set_pins(3'b100);
    av_xfer(1'b1, `REG_IRQ_STAT, 32'h7);
    av_xfer(1'b1, `REG_IRQ_MASK, 32'h7);
    chk({31'h0, irq}, 32'h0);
    set_pins(3'b001);
    av_xfer(1'b0, `REG_STATUS, 32'h0);
    chk(rd, 32'h1);
    av_xfer(1'b0, `REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h1);
    av_xfer(1'b1, `REG_CTRL, 32'h84);
    av_xfer(1'b0, `REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h7);
    av_xfer(1'b1, `REG_IRQ_STAT, 32'h1);
    av_xfer(1'b0, `REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h6);
    av_xfer(1'b1, `REG_IRQ_MASK, 32'h1);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    av_xfer(1'b1, `REG_IRQ_STAT, 32'h6);
    av_xfer(1'b0, `REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    // Unmapped place reads zero and ignores writes
    av_xfer(1'b1, 4'hf, 32'hff);
    av_xfer(1'b0, 4'hf, 32'h0);
    chk(rd, 32'h0);
    av_xfer(1'b0, `REG_CTRL, 32'h0);
    chk(rd, 32'h84);
    // Second reset in mid-run
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({25'h0, leds}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Release again: power lamp alone, then battery edge caught after the synchroniser
    @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({25'h0, leds}, 32'h40);
    av_xfer(1'b0, `REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    repeat (8) @(posedge sys_clk);
    av_xfer(1'b0, `REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
    chk({31'h0, irq}, 32'h0);
    print_verdict();
  end
endmodule : tb_node_status_led_driver
`default_nettype wire
